/* verif/ppc_link_partner.sv */
// Cable link partner model answering the advertisement
`timescale 1ns/10ps
module ppc_link_partner (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [9:0] adv,
   input wire logic [1:0] restart,
   output logic [1:0] fail,
   output logic [1:0] fdx,
   output logic [1:0] s100,
   output logic [1:0] mdi
);
   // Best common mode; nothing in common fails the match
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {fail, fdx, s100} <= 6'h00;
         mdi <= 2'h3;
      end else begin
         for (int p = 0; p < 2; p++) begin
            fail[p] <= ~|adv[5*p +: 4];
            s100[p] <= |adv[5*p+2 +: 2];
            // Duplex belongs to the chosen speed, not to either one
            fdx[p] <= (|adv[5*p+2 +: 2]) ? adv[5*p+3]
                                         : adv[5*p+1];
            mdi[p] <= mdi[p] ^ restart[p];
         end
      end
   end
endmodule : ppc_link_partner

/* verif/ppc_regs_properties.sv */
// Concurrent checks on the port control register bank
`timescale 1ns/10ps
module ppc_regs_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] port_full_duplex,
   input wire logic [1:0] port_speed_100,
   input wire logic [9:0] port_advertise,
   input wire logic [1:0] port_led_output_one,
   input wire logic [1:0] port_led_output_zero,
   input wire logic [1:0] port_tx_disable,
   input wire logic [1:0] port_an_restart,
   input wire logic [1:0] port_power_down,
   input wire logic [1:0] port_tx_on_receive_pair
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Port one writes and its effective speed and duplex
   wire wa = reg_wr && reg_addr == 8'h1c;
   wire wb = reg_wr && reg_addr == 8'h1d;
   wire [7:0] d = reg_wdata;
   wire [1:0] sd = {port_speed_100[0], port_full_duplex[0]};
   property p_rsv;
      reg_rd && reg_addr == 8'h3d |=> reg_rdata == 8'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved read");
   property p_adv;
      wa |=> port_advertise[4:0] == $past(d[4:0]); endproperty
   a_adv: assert property (p_adv) else $error("advert");
   property p_frc;
      wa && !d[7] |-> ##2 sd == $past(d[6:5], 2); endproperty
   a_frc: assert property (p_frc) else $error("forced");
   property p_led;
      wb && d[7] |-> ##2 port_led_output_one[0] && port_led_output_zero[0];
   endproperty
   a_led: assert property (p_led) else $error("led off");
   property p_tx;
      wb |=> port_tx_disable[0] == $past(d[6]); endproperty
   a_tx: assert property (p_tx) else $error("tx disable");
   property p_pwr;
      wb |=> port_power_down[0] == $past(d[3]); endproperty
   a_pwr: assert property (p_pwr) else $error("power down");
   property p_mdi;
      wb && d[2] |-> ##2 port_tx_on_receive_pair[0] == $past(d[1], 2);
   endproperty
   a_mdi: assert property (p_mdi) else $error("mdi");
   property p_rst;
      $rose(port_an_restart[0]) |-> ($past(wb) && $past(d[5]))
         ##1 !port_an_restart[0]; endproperty
   a_rst: assert property (p_rst) else $error("rst");
   // Main scenarios reached
   c_rst: cover property (port_an_restart[0]);
   c_led: cover property (wb && d[7]);
   c_rsv: cover property (reg_rd && reg_addr == 8'h3d);
endmodule : ppc_regs_checker
bind ppc_regs ppc_regs_checker u_ppc_regs_checker (.*);

/* verif/ppc_regs_tb.sv */
// Self-checking bench of the PHY port control registers
`timescale 1ns/10ps
module ppc_regs_tb;
   logic clk, rst_b, wr_s, rd_s;
   logic [7:0] addr, wdat, rdat;
   logic [1:0] fail, lfd, l100, amdi, fdx, spd, l1, l0, txd, rp, fef, pwr;
   logic [1:0] mdx, mdi, ane;
   logic [9:0] adv;
   int err_count, n_tests, pulses, cyc;
   // PHY LED one modelled as off when powered down; LED zero lit by full duplex
   ppc_regs u_ppc_regs (.clk(clk), .rst_b(rst_b), .reg_addr(addr),
      .reg_wr(wr_s), .reg_wdata(wdat), .reg_rd(rd_s), .reg_rdata(rdat),
      .port1_duplex_strap_pin(1'b1), .port2_duplex_strap_pin(1'b0),
      .port_an_enable_strap(2'h0), .port_speed_strap(2'h1),
      .phy_an_failed(fail), .phy_link_full_duplex(lfd),
      .phy_link_speed_100(l100), .phy_auto_mdi(amdi), .phy_led_one(pwr),
      .phy_led_zero(~lfd), .port_full_duplex(fdx), .port_speed_100(spd),
      .port_an_enable(ane), .port_advertise(adv), .port_led_output_one(l1),
      .port_led_output_zero(l0), .port_tx_disable(txd),
      .port_an_restart(rp), .port_fef_disable(fef), .port_power_down(pwr),
      .port_mdix_auto_off(mdx), .port_tx_on_receive_pair(mdi));
   ppc_link_partner u_ppc_link_partner (.clk(clk), .rst_b(rst_b),
      .adv(adv), .restart(rp), .fail(fail), .fdx(lfd), .s100(l100),
      .mdi(amdi));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Restart pulse tally; ceiling well above the run length
   always @(posedge clk) begin
      cyc++;
      pulses += int'(rp[0] === 1'b1);
      if (cyc == 1000) begin
         err_count++;
         stop_test;
      end
   end
   task automatic chk(input logic [9:0] s, input logic [9:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: %h seen, %h expected", $time, s, e);
      end
   endtask : chk
   // One access; settles effective outputs before returning
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      {wr_s, rd_s, addr, wdat} = {w, ~w, a, d};
      @(negedge clk);
      {wr_s, rd_s} = 2'h0;
      repeat (2) @(negedge clk);
      if (!w) chk({2'h0, rdat}, {2'h0, d});
   endtask : acc
   task automatic stop_test;
      $display("%0d checks, %0d mismatches", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   initial begin
      {rst_b, wr_s, rd_s, addr, wdat} = 19'h0;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      acc(0, 8'h1c, 8'h7f);
      acc(0, 8'h2c, 8'h1f);
      chk({6'h0, spd, fdx}, 10'h005);
      $display("test 1 done");
      acc(1, 8'h1c, 8'h30);
      chk({spd, fdx, adv[5:0]}, 10'h070);
      // Negotiation on but failing keeps the forced duplex
      acc(1, 8'h1c, 8'ha0);
      repeat (2) @(negedge clk);
      chk({6'h0, spd, fdx}, 10'h001);
      acc(1, 8'h1c, 8'h88);
      repeat (2) @(negedge clk);
      chk({4'h0, ane, spd, fdx}, 10'h015);
      // Only 100 half and 10 full offered: partner settles on 100 half
      acc(1, 8'h1c, 8'h86);
      repeat (2) @(negedge clk);
      chk({6'h0, spd, fdx}, 10'h004);
      $display("test 2 done");
      acc(1, 8'h1d, 8'hde);
      acc(0, 8'h1d, 8'hde);
      chk({4'h0, l1, l0, txd}, 10'h015);
      chk({6'h0, fef, pwr}, 10'h005);
      acc(1, 8'h2d, 8'h14);
      chk({6'h0, mdx, mdi}, 10'h00d);
      $display("test 3 done");
      acc(1, 8'h1d, 8'h20);
      acc(1, 8'h1d, 8'h20);
      chk(10'(pulses), 10'h001);
      acc(1, 8'h3d, 8'hff);
      acc(0, 8'h3d, 8'h00);
      acc(0, 8'h55, 8'h00);
      acc(0, 8'h1d, 8'h20);
      acc(1, 8'h2d, 8'h01);
      acc(0, 8'h2d, 8'h00);
      // Auto crossover back on: port 1 result flipped by its restart
      chk({6'h0, mdx, mdi}, 10'h002);
      $display("test 4 done");
      stop_test;
   end
endmodule : ppc_regs_tb

/* verilog/ppc_cfg.svh */
// Register offsets, field positions and reset values of the PHY port control
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// Register addresses on the management register port
`define PPC_P1_CTL_A 8'h1c
`define PPC_P1_CTL_B 8'h1d
`define PPC_P2_CTL_A 8'h2c
`define PPC_P2_CTL_B 8'h2d
`define PPC_P3_CTL_A 8'h3c
`define PPC_P3_CTL_B 8'h3d

// Negotiation control register fields
`define PPC_A_AN_EN 7
`define PPC_A_SPEED 6
`define PPC_A_DUPLEX 5
`define PPC_A_ADV_HI 4
`define PPC_A_ADV_LO 0
`define PPC_A_ADV_RST 5'h1f

// Second control register fields
`define PPC_B_LED_OFF 7
`define PPC_B_TX_DIS 6
`define PPC_B_RESTART 5
`define PPC_B_FEF_DIS 4
`define PPC_B_PWR_DOWN 3
`define PPC_B_MDIX_DIS 2
`define PPC_B_FORCE_MDI 1
`define PPC_B_LOOPBACK 0
`define PPC_B_LOOP_RD 1'b0
`define PPC_B_RST 8'h00

// Read value of reserved or unmapped locations
`define PPC_RD_ZERO 8'h00

`endif

/* verilog/ppc_pkg.sv */
// Shared types of the PHY port control register bank
package ppc_pkg;

   // One management register byte
   typedef logic [7:0] ppc_byte_type;

   // Ability advertisement: pause, 100 FD, 100 HD, 10 FD, 10 HD
   typedef logic [4:0] ppc_adv_type;

endpackage : ppc_pkg

/* verilog/ppc_regs.sv */
// Per-port PHY control registers for the two copper ports
`timescale 1ns/10ps
`include "ppc_cfg.svh"

module ppc_regs (
   input wire logic clk,
   input wire logic rst_b,
   // Management register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Strap pins, sampled after reset release
   input wire logic port1_duplex_strap_pin,
   input wire logic port2_duplex_strap_pin,
   input wire logic [1:0] port_an_enable_strap,
   input wire logic [1:0] port_speed_strap,
   // Status from each port PHY core
   input wire logic [1:0] phy_an_failed,
   input wire logic [1:0] phy_link_full_duplex,
   input wire logic [1:0] phy_link_speed_100,
   input wire logic [1:0] phy_auto_mdi,
   input wire logic [1:0] phy_led_one,
   input wire logic [1:0] phy_led_zero,
   // Controls toward each port PHY
   output logic [1:0] port_full_duplex,
   output logic [1:0] port_speed_100,
   output logic [1:0] port_an_enable,
   output logic [9:0] port_advertise,
   output logic [1:0] port_led_output_one,
   output logic [1:0] port_led_output_zero,
   output logic [1:0] port_tx_disable,
   output logic [1:0] port_an_restart,
   output logic [1:0] port_fef_disable,
   output logic [1:0] port_power_down,
   output logic [1:0] port_mdix_auto_off,
   output logic [1:0] port_tx_on_receive_pair
);

   // Straps are caught once, on the first edge after release
   logic strap_done_q;
   logic [1:0] duplex_strap;
   ppc_pkg::ppc_byte_type ctl_a_rd [1:0];
   ppc_pkg::ppc_byte_type ctl_b_rd [1:0];
   ppc_pkg::ppc_byte_type rdata_d;
   ppc_pkg::ppc_byte_type rdata_q;

   // Reset image of the second control register, one field per flop
   localparam ppc_pkg::ppc_byte_type CTL_B_RST = `PPC_B_RST;

   assign duplex_strap = {port2_duplex_strap_pin, port1_duplex_strap_pin};

   // Strap capture window closes after one cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_done_q <= 1'b0;
      end else begin
         strap_done_q <= 1'b1;
      end
   end

   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_port
         // Each port decodes its own pair of addresses
         localparam logic [7:0] ADDR_A = (p == 0) ? `PPC_P1_CTL_A
                                                  : `PPC_P2_CTL_A;
         localparam logic [7:0] ADDR_B = (p == 0) ? `PPC_P1_CTL_B
                                                  : `PPC_P2_CTL_B;
         logic wr_a;
         logic wr_b;
         logic an_en_q;
         logic speed_q;
         logic duplex_q;
         ppc_pkg::ppc_adv_type adv_q;
         logic led_off_q;
         logic tx_dis_q;
         logic restart_bit_q;
         logic fef_dis_q;
         logic pwr_down_q;
         logic mdix_dis_q;
         logic force_mdi_q;
         logic restart_q;
         logic full_q;
         logic spd_q;
         logic led1_q;
         logic led0_q;
         logic mdi_q;

         assign wr_a = reg_wr && (reg_addr == ADDR_A);
         assign wr_b = reg_wr && (reg_addr == ADDR_B);

         // Negotiation enable: strap first, software after capture
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               an_en_q <= 1'b0;
            end else if (!strap_done_q) begin
               an_en_q <= port_an_enable_strap[p];
            end else if (wr_a) begin
               an_en_q <= reg_wdata[`PPC_A_AN_EN];
            end
         end

         // Forced speed: strap first, software after capture
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               speed_q <= 1'b0;
            end else if (!strap_done_q) begin
               speed_q <= port_speed_strap[p];
            end else if (wr_a) begin
               speed_q <= reg_wdata[`PPC_A_SPEED];
            end
         end

         // Forced duplex; a write in the capture cycle loses to the strap
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               duplex_q <= 1'b0;
            end else if (!strap_done_q) begin
               duplex_q <= duplex_strap[p];
            end else if (wr_a) begin
               duplex_q <= reg_wdata[`PPC_A_DUPLEX];
            end
         end

         // Advertise bits reset to all abilities on
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               adv_q <= `PPC_A_ADV_RST;
            end else if (wr_a) begin
               adv_q <= reg_wdata[`PPC_A_ADV_HI:`PPC_A_ADV_LO];
            end
         end

         // LED suppression
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               led_off_q <= CTL_B_RST[`PPC_B_LED_OFF];
            end else if (wr_b) begin
               led_off_q <= reg_wdata[`PPC_B_LED_OFF];
            end
         end

         // Transmitter disable
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               tx_dis_q <= CTL_B_RST[`PPC_B_TX_DIS];
            end else if (wr_b) begin
               tx_dis_q <= reg_wdata[`PPC_B_TX_DIS];
            end
         end

         // Restart bit kept as written, so a repeat write stays quiet
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               restart_bit_q <= CTL_B_RST[`PPC_B_RESTART];
            end else if (wr_b) begin
               restart_bit_q <= reg_wdata[`PPC_B_RESTART];
            end
         end

         // Far-end fault disable
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               fef_dis_q <= CTL_B_RST[`PPC_B_FEF_DIS];
            end else if (wr_b) begin
               fef_dis_q <= reg_wdata[`PPC_B_FEF_DIS];
            end
         end

         // PHY power-down request
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               pwr_down_q <= CTL_B_RST[`PPC_B_PWR_DOWN];
            end else if (wr_b) begin
               pwr_down_q <= reg_wdata[`PPC_B_PWR_DOWN];
            end
         end

         // Automatic crossover disable
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               mdix_dis_q <= CTL_B_RST[`PPC_B_MDIX_DIS];
            end else if (wr_b) begin
               mdix_dis_q <= reg_wdata[`PPC_B_MDIX_DIS];
            end
         end

         // Forced crossover choice, used only while auto is off
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               force_mdi_q <= CTL_B_RST[`PPC_B_FORCE_MDI];
            end else if (wr_b) begin
               force_mdi_q <= reg_wdata[`PPC_B_FORCE_MDI];
            end
         end

         // One restart pulse per rising write of the restart bit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               restart_q <= 1'b0;
            end else begin
               restart_q <= wr_b && reg_wdata[`PPC_B_RESTART]
                            && !restart_bit_q;
            end
         end

         // Forced duplex when negotiation is off or failed; forced speed only when it is off
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               full_q <= 1'b0;
               spd_q <= 1'b0;
            end else if (!an_en_q || phy_an_failed[p]) begin
               full_q <= duplex_q;
               spd_q <= !an_en_q ? speed_q
                                 : phy_link_speed_100[p];
            end else begin
               full_q <= phy_link_full_duplex[p];
               spd_q <= phy_link_speed_100[p];
            end
         end

         // LED-off forces both pins high, i.e. unlit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               led1_q <= 1'b1;
               led0_q <= 1'b1;
            end else begin
               led1_q <= led_off_q | phy_led_one[p];
               led0_q <= led_off_q | phy_led_zero[p];
            end
         end

         // Crossover: forced choice only while auto detection is off
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               mdi_q <= 1'b0;
            end else if (mdix_dis_q) begin
               mdi_q <= force_mdi_q;
            end else begin
               mdi_q <= phy_auto_mdi[p];
            end
         end

         assign ctl_a_rd[p] = {an_en_q, speed_q, duplex_q, adv_q};
         // Read image of the second register; loopback is not held here
         assign ctl_b_rd[p][`PPC_B_LED_OFF] = led_off_q;
         assign ctl_b_rd[p][`PPC_B_TX_DIS] = tx_dis_q;
         assign ctl_b_rd[p][`PPC_B_RESTART] = restart_bit_q;
         assign ctl_b_rd[p][`PPC_B_FEF_DIS] = fef_dis_q;
         assign ctl_b_rd[p][`PPC_B_PWR_DOWN] = pwr_down_q;
         assign ctl_b_rd[p][`PPC_B_MDIX_DIS] = mdix_dis_q;
         assign ctl_b_rd[p][`PPC_B_FORCE_MDI] = force_mdi_q;
         assign ctl_b_rd[p][`PPC_B_LOOPBACK] = `PPC_B_LOOP_RD;

         // Plain control bits straight from their flops
         assign port_an_enable[p] = an_en_q;
         assign port_advertise[p*5 +: 5] = adv_q;
         assign port_tx_disable[p] = tx_dis_q;
         assign port_fef_disable[p] = fef_dis_q;
         assign port_power_down[p] = pwr_down_q;
         assign port_mdix_auto_off[p] = mdix_dis_q;
         assign port_an_restart[p] = restart_q;
         assign port_full_duplex[p] = full_q;
         assign port_speed_100[p] = spd_q;
         assign port_led_output_one[p] = led1_q;
         assign port_led_output_zero[p] = led0_q;
         assign port_tx_on_receive_pair[p] = mdi_q;
      end
   endgenerate

   // Read decode; third-port and unmapped locations read zero
   always_comb begin
      case (reg_addr)
         `PPC_P1_CTL_A: rdata_d = ctl_a_rd[0];
         `PPC_P1_CTL_B: rdata_d = ctl_b_rd[0];
         `PPC_P2_CTL_A: rdata_d = ctl_a_rd[1];
         `PPC_P2_CTL_B: rdata_d = ctl_b_rd[1];
         `PPC_P3_CTL_B: rdata_d = `PPC_RD_ZERO;
         default: rdata_d = `PPC_RD_ZERO;
      endcase
   end

   // Read data is held until the next read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= `PPC_RD_ZERO;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : ppc_regs
